// ==== hw/wdcm_top.sv ====
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/100ps

module wdcm_top
    import wdcm_pkg::*;
#(
    parameter int PRESCALE = WD_PRESCALE
) (
    input  wire logic                sys_clk,
    input  wire logic                rst,
    input  wire logic [ADDR_W-1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    input  wire logic                special_mode,
    input  wire logic                clk_edge_timeout,
    input  wire logic                halt_active,
    input  wire logic                reset_pin_in,
    output logic                     reset_pin_out,
    output logic                     reset_pin_oe,
    output logic                     sys_reset,
    output logic      [15:0]         reset_vector,
    output logic                     interrupt_edge_select,
    output logic                     stop_exit_delay,
    output logic                     clock_monitor_enable,
    output logic                     irq
);
    import wdcm_pkg::*;

    if (PRESCALE < 2 || PRESCALE > 65536) begin : gen_bad_prescale
        $error("PRESCALE out of range");
    end

    // ****************************************
    // Bus slave
    // ****************************************
    logic              wait_q;
    logic [31:0]       rdata_q;
    logic              acc_done;
    logic              wr_en;
    logic [7:0]        idx;
    logic [7:0]        wbyte;

    assign acc_done = (avs_read || avs_write) && !wait_q;
    assign wr_en    = avs_write && !wait_q;
    assign idx      = avs_address[ADDR_W-1:2];
    assign wbyte    = avs_writedata[7:0];

    // One wait state: waitrequest drops for exactly the completing edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wait_q <= 1'b1;
        end else if (acc_done) begin
            wait_q <= 1'b1;
        end else if (avs_read || avs_write) begin
            wait_q <= 1'b0;
        end
    end

    // ****************************************
    // Mode capture and protection window
    // ****************************************
    logic              boot_q;
    logic              special_q;
    logic [6:0]        win_cnt_q;
    logic              win_open;
    logic              soft_rst;

    assign win_open = (win_cnt_q < 7'(PROTECT_CYCLES));

    // Strap caught after reset release, never by the async branch
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            boot_q    <= 1'b1;
            special_q <= 1'b0;
        end else if (boot_q) begin
            boot_q    <= 1'b0;
            special_q <= special_mode;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            win_cnt_q <= '0;
        end else if (soft_rst) begin
            win_cnt_q <= '0;
        end else if (win_open) begin
            win_cnt_q <= win_cnt_q + 7'h01;
        end
    end

    // ****************************************
    // Option, setup and test registers
    // ****************************************
    logic              edge_q;
    logic              dly_q;
    logic              cme_q;
    logic [1:0]        rate_q;
    logic              opt_done_q;
    logic              nowd_q;
    logic              nowd_done_q;
    logic              rom_q;
    logic              disable_resets_test_bit_q;
    logic              opt_wr;
    logic              opt_ok;
    logic              set_wr;

    assign opt_wr = wr_en && (idx == IDX_OPTIONS);
    assign opt_ok = special_q || (win_open && !opt_done_q);
    assign set_wr = wr_en && (idx == IDX_SETUP);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            edge_q     <= 1'b0;
            dly_q      <= DLY_RESET;
            rate_q     <= RATE_RESET;
            opt_done_q <= 1'b0;
        end else if (soft_rst) begin
            edge_q     <= 1'b0;
            dly_q      <= DLY_RESET;
            rate_q     <= RATE_RESET;
            opt_done_q <= 1'b0;
        end else if (opt_wr && opt_ok) begin
            edge_q     <= wbyte[OPT_EDGE_BIT];
            dly_q      <= wbyte[OPT_DLY_BIT];
            rate_q     <= wbyte[OPT_RATE_LO +: 2];
            opt_done_q <= 1'b1;
        end
    end

    // Monitor enable has no write protection
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cme_q <= 1'b0;
        end else if (soft_rst) begin
            cme_q <= 1'b0;
        end else if (opt_wr) begin
            cme_q <= wbyte[OPT_CME_BIT];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nowd_q      <= 1'b0;
            nowd_done_q <= 1'b0;
            rom_q       <= 1'b1;
            disable_resets_test_bit_q      <= 1'b0;
        end else if (boot_q || soft_rst) begin
            nowd_q      <= boot_q ? special_mode : special_q;
            nowd_done_q <= 1'b0;
            rom_q       <= 1'b1;
            disable_resets_test_bit_q      <= boot_q ? special_mode : special_q;
        end else begin
            if (set_wr && (special_q || !nowd_done_q)) begin
                nowd_q      <= wbyte[SET_NOWD_BIT];
                rom_q       <= wbyte[SET_ROM_BIT];
                nowd_done_q <= 1'b1;
            end
            if (wr_en && idx == IDX_TEST && special_q) begin
                disable_resets_test_bit_q <= wbyte[TEST_DISABLE_RESETS_TEST_BIT_BIT];
            end
        end
    end

    // ****************************************
    // Watchdog
    // ****************************************
    logic [15:0]       pre_q;
    logic [5:0]        wdc_q;
    logic              armed_q;
    logic              pre_tick;
    logic              wd_clear;
    logic              wd_run;
    logic [5:0]        wd_last;
    logic              wd_expire;

    assign pre_tick  = (pre_q == 16'(PRESCALE - 1));
    assign wd_clear  = wr_en && idx == IDX_SERVICE && wbyte == SERVICE_CLEAR && armed_q;
    assign wd_run    = !nowd_q && !disable_resets_test_bit_q && !boot_q;
    assign wd_last   = 6'((7'h01 << {rate_q, 1'b0}) - 7'h01);
    assign wd_expire = wd_run && pre_tick && (wdc_q == wd_last);

    // Held clear for the whole sequence, so counting restarts at its release
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pre_q <= '0;
            wdc_q <= '0;
        end else if (soft_rst || sysr_q || wd_clear) begin
            pre_q <= '0;
            wdc_q <= '0;
        end else if (pre_tick) begin
            pre_q <= '0;
            wdc_q <= (wdc_q == wd_last) ? 6'h00 : wdc_q + 6'h01;
        end else begin
            pre_q <= pre_q + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            armed_q <= 1'b0;
        end else if (soft_rst || sysr_q || wd_clear) begin
            armed_q <= 1'b0;
        end else if (wr_en && idx == IDX_SERVICE && wbyte == SERVICE_ARM) begin
            armed_q <= 1'b1;
        end
    end

    // ****************************************
    // Clock monitor
    // ****************************************
    logic              clk_fail;

    // Delay element is analog and clock-free; a halt stops the clock outright
    assign clk_fail = cme_q && !boot_q && (clk_edge_timeout || halt_active);

    // ****************************************
    // Reset sequencer
    // ****************************************
    typedef enum logic [1:0] {
        SQ_RUN,
        SQ_DRIVE,
        SQ_RELEASE,
        SQ_EXTERNAL
    } wdcm_seq_t;

    wdcm_seq_t         seq_q;
    logic [2:0]        seq_cnt_q;
    wdcm_cause_t       cause_q;
    logic              oe_q;
    logic              sysr_q;
    logic [15:0]       vec_q;
    logic              ext_event;
    logic              trigger;

    assign trigger   = (seq_q == SQ_RUN) && (clk_fail || wd_expire);
    assign ext_event = ((seq_q == SQ_RUN) && !reset_pin_in && !boot_q) ||
                       ((seq_q == SQ_RELEASE) && seq_cnt_q == PIN_SAMPLE_CYC - 3'h1
                        && !reset_pin_in);
    assign soft_rst  = trigger || ext_event;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            seq_q     <= SQ_RUN;
            seq_cnt_q <= '0;
            cause_q   <= CAUSE_POR;
            oe_q      <= 1'b0;
            sysr_q    <= 1'b0;
        end else begin
            case (seq_q)
                SQ_RUN: begin
                    seq_cnt_q <= '0;
                    if (trigger) begin
                        seq_q   <= SQ_DRIVE;
                        cause_q <= clk_fail ? CAUSE_CLK : CAUSE_WD;
                        oe_q    <= 1'b1;
                        sysr_q  <= 1'b1;
                    end else if (ext_event) begin
                        seq_q   <= SQ_EXTERNAL;
                        cause_q <= CAUSE_POR;
                        sysr_q  <= 1'b1;
                    end
                end
                SQ_DRIVE: begin
                    seq_cnt_q <= seq_cnt_q + 3'h1;
                    if (seq_cnt_q == PIN_DRIVE_CYC - 3'h1) begin
                        seq_q     <= SQ_RELEASE;
                        seq_cnt_q <= '0;
                        oe_q      <= 1'b0;
                    end
                end
                SQ_RELEASE: begin
                    seq_cnt_q <= seq_cnt_q + 3'h1;
                    if (seq_cnt_q == PIN_SAMPLE_CYC - 3'h1) begin
                        if (!reset_pin_in) begin
                            seq_q   <= SQ_EXTERNAL;
                            cause_q <= CAUSE_POR;
                        end else begin
                            seq_q  <= SQ_RUN;
                            sysr_q <= 1'b0;
                        end
                    end
                end
                SQ_EXTERNAL: begin
                    if (reset_pin_in) begin
                        seq_q  <= SQ_RUN;
                        sysr_q <= 1'b0;
                    end
                end
                default: begin
                    seq_q  <= SQ_RUN;
                    oe_q   <= 1'b0;
                    sysr_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            vec_q <= VEC_POR_NORM;
        end else begin
            case (cause_q)
                CAUSE_CLK: vec_q <= special_q ? VEC_CLK_SPEC : VEC_CLK_NORM;
                CAUSE_WD:  vec_q <= special_q ? VEC_WD_SPEC : VEC_WD_NORM;
                default:   vec_q <= special_q ? VEC_POR_SPEC : VEC_POR_NORM;
            endcase
        end
    end

    // ****************************************
    // Event status, mask and interrupt
    // ****************************************
    logic [EV_W-1:0]   stat_q;
    logic [EV_W-1:0]   mask_q;
    logic [EV_W-1:0]   ev_set;
    logic              irq_q;

    assign ev_set = {ext_event, trigger && clk_fail, trigger && !clk_fail};

    // Set beats a same-cycle write-one clear; chip reset only clears these
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stat_q <= '0;
            mask_q <= '0;
        end else begin
            if (wr_en && idx == IDX_STATUS) begin
                stat_q <= (stat_q & ~avs_writedata[EV_W-1:0]) | ev_set;
            end else begin
                stat_q <= stat_q | ev_set;
            end
            if (wr_en && idx == IDX_MASK) begin
                mask_q <= avs_writedata[EV_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_q & mask_q);
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (avs_read && wait_q) begin
            case (idx)
                IDX_OPTIONS: rdata_q <= {24'h0000_00, 2'h0, edge_q, dly_q, cme_q,
                                         1'b0, rate_q};
                IDX_SETUP:   rdata_q <= {24'h0000_00, 4'h0, 1'b0, nowd_q, rom_q,
                                         1'b0};
                IDX_TEST:    rdata_q <= {31'h0000_0000, disable_resets_test_bit_q};
                IDX_STATUS:  rdata_q <= {29'h0000_0000, stat_q};
                IDX_MASK:    rdata_q <= {29'h0000_0000, mask_q};
                IDX_CAUSE:   rdata_q <= {14'h0000, cause_q, vec_q};
                default:     rdata_q <= '0;
            endcase
        end
    end

    assign avs_readdata          = rdata_q;
    assign avs_waitrequest       = wait_q;
    assign reset_pin_out         = 1'b0;
    assign reset_pin_oe          = oe_q;
    assign sys_reset             = sysr_q;
    assign reset_vector          = vec_q;
    assign interrupt_edge_select = edge_q;
    assign stop_exit_delay       = dly_q;
    assign clock_monitor_enable  = cme_q;
    assign irq                   = irq_q;
endmodule

// ==== hw/wdcm_pkg.sv ====
package wdcm_pkg;
    // ****************************************
    // Register indices (byte address = 4 * index)
    // ****************************************
    localparam logic [7:0] IDX_SERVICE  = 8'h3A;
    localparam logic [7:0] IDX_OPTIONS  = 8'h39;
    localparam logic [7:0] IDX_TEST     = 8'h3E;
    localparam logic [7:0] IDX_SETUP    = 8'h3F;
    localparam logic [7:0] IDX_STATUS   = 8'h40;
    localparam logic [7:0] IDX_MASK     = 8'h41;
    localparam logic [7:0] IDX_CAUSE    = 8'h42;
    localparam int         ADDR_W       = 10;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int OPT_EDGE_BIT  = 5;
    localparam int OPT_DLY_BIT   = 4;
    localparam int OPT_CME_BIT   = 3;
    localparam int OPT_RATE_LO   = 0;
    localparam int SET_NOWD_BIT  = 2;
    localparam int SET_ROM_BIT   = 1;
    localparam int TEST_DISABLE_RESETS_TEST_BIT_BIT = 0;
    localparam int EV_WD         = 0;
    localparam int EV_CLK        = 1;
    localparam int EV_EXT        = 2;
    localparam int EV_W          = 3;

    // ****************************************
    // Masks and reset values
    // ****************************************
    localparam logic [7:0] OPTIONS_MASK  = 8'h3B;
    localparam logic [7:0] SETUP_MASK    = 8'h0E;
    localparam logic [7:0] SERVICE_ARM   = 8'h55;
    localparam logic [7:0] SERVICE_CLEAR = 8'hAA;
    localparam logic [1:0] RATE_RESET    = 2'h0;
    localparam logic       DLY_RESET     = 1'b1;

    // ****************************************
    // Timing
    // ****************************************
    localparam int         SYS_CLK_HZ     = 10_000_000;
    localparam int         WD_PRESCALE    = 32768;
    localparam int         PROTECT_CYCLES = 64;
    localparam logic [2:0] PIN_DRIVE_CYC  = 3'h4;
    localparam logic [2:0] PIN_SAMPLE_CYC = 3'h2;

    // ****************************************
    // Reset vectors
    // ****************************************
    localparam logic [15:0] VEC_POR_NORM  = 16'hFFFE;
    localparam logic [15:0] VEC_CLK_NORM  = 16'hFFFC;
    localparam logic [15:0] VEC_WD_NORM   = 16'hFFFA;
    localparam logic [15:0] VEC_POR_SPEC  = 16'hBFFE;
    localparam logic [15:0] VEC_CLK_SPEC  = 16'hBFFC;
    localparam logic [15:0] VEC_WD_SPEC   = 16'hBFFA;

    typedef enum logic [1:0] {
        CAUSE_POR,
        CAUSE_CLK,
        CAUSE_WD
    } wdcm_cause_t;
endpackage

// ==== verification/wdcm_monitor.sv ====
`timescale 1ns/100ps
// ********************
// Port checker
// ********************
module wdcm_monitor #(
    parameter int PRESCALE = wdcm_pkg::WD_PRESCALE
) (
    input wire logic                        sys_clk,
    input wire logic                        rst,
    input wire logic [wdcm_pkg::ADDR_W-1:0] avs_address,
    input wire logic                        avs_read,
    input wire logic                        avs_write,
    input wire logic [31:0]                 avs_writedata,
    input wire logic [31:0]                 avs_readdata,
    input wire logic                        avs_waitrequest,
    input wire logic                        special_mode,
    input wire logic                        clk_edge_timeout,
    input wire logic                        halt_active,
    input wire logic                        reset_pin_in,
    input wire logic                        reset_pin_out,
    input wire logic                        reset_pin_oe,
    input wire logic                        sys_reset,
    input wire logic [15:0]                 reset_vector,
    input wire logic                        interrupt_edge_select,
    input wire logic                        stop_exit_delay,
    input wire logic                        clock_monitor_enable,
    input wire logic                        irq
);
    import wdcm_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    bus_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    pin_drive_a: assert property ($rose(reset_pin_oe) |-> reset_pin_oe [*4] ##1 !reset_pin_oe)
        else $error("reset pin drive length wrong");
    pin_release_a: assert property ($fell(reset_pin_oe) |-> sys_reset [*2])
        else $error("sequence ended before pin sample");
    drive_in_seq_a: assert property (reset_pin_oe |-> sys_reset && !reset_pin_out)
        else $error("pin driven outside sequence");
    clock_fail_a: assert property (clock_monitor_enable && clk_edge_timeout && !sys_reset
        |-> ##[1:2] sys_reset)
        else $error("clock failure ignored");
    halt_fail_a: assert property (clock_monitor_enable && halt_active && !sys_reset
        |-> ##[1:2] sys_reset)
        else $error("halt with monitor ignored");
    seq_length_a: assert property ($rose(sys_reset) |-> sys_reset [*6])
        else $error("reset sequence too short");
    soft_init_a: assert property ($fell(sys_reset) |-> !clock_monitor_enable
        && stop_exit_delay && !interrupt_edge_select)
        else $error("options not reinitialised");
    vector_mode_a: assert property ($fell(sys_reset) |->
        reset_vector[15:12] == (special_mode ? 4'hB : 4'hF)
        && reset_vector[11:0] inside {12'hFFE, 12'hFFC, 12'hFFA})
        else $error("reset vector wrong");

    cover property ($rose(sys_reset));
    cover property (clock_monitor_enable && halt_active);
    cover property ($rose(irq));
endmodule

bind wdcm_top wdcm_monitor #(.PRESCALE(PRESCALE)) u_mon (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .special_mode(special_mode),
    .clk_edge_timeout(clk_edge_timeout), .halt_active(halt_active),
    .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .sys_reset(sys_reset), .reset_vector(reset_vector),
    .interrupt_edge_select(interrupt_edge_select), .stop_exit_delay(stop_exit_delay),
    .clock_monitor_enable(clock_monitor_enable), .irq(irq));

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
    import wdcm_pkg::*;
    // Short prescale keeps the longest timeout near four thousand cycles
    localparam int PS = 64;
    logic              sys_clk, rst, avs_read, avs_write, special_mode;
    logic              clk_edge_timeout, halt_active, ext_n, avs_waitrequest;
    logic              reset_pin_out, reset_pin_oe, sys_reset, irq;
    logic              interrupt_edge_select, stop_exit_delay, clock_monitor_enable;
    logic [ADDR_W-1:0] avs_address;
    logic [31:0]       avs_writedata, avs_readdata, rd;
    logic [15:0]       reset_vector, lfsr_q;
    int                failures, n_checks, hits, t0, dt;
    int                cyc = 0;
    // Open drain pin with pull-up
    wire               reset_pin_in = reset_pin_oe ? reset_pin_out : ext_n;

    wdcm_top #(.PRESCALE(PS)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .special_mode(special_mode),
        .clk_edge_timeout(clk_edge_timeout), .halt_active(halt_active),
        .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
        .reset_pin_oe(reset_pin_oe), .sys_reset(sys_reset), .reset_vector(reset_vector),
        .interrupt_edge_select(interrupt_edge_select), .stop_exit_delay(stop_exit_delay),
        .clock_monitor_enable(clock_monitor_enable), .irq(irq));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= cyc + 1;

    // ********************
    // Helpers
    // ********************
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [31:0] cause_exp(input logic [1:0] c, input logic spec);
        return {14'h0, c, spec ? 8'hBF : 8'hFF, 8'hFE - {5'h0, c, 1'b0}};
    endfunction
    task automatic complete_run;
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        @(posedge sys_clk);
        avs_address <= {idx, 2'b00};
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= wd;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20) begin
            failures++;
            complete_run();
        end
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        check(rd, exp);
    endtask
    // Waits for a reset sequence to start, then for it to end
    task automatic wait_rst(input int lim);
        int n;
        n = 0;
        while (sys_reset !== 1'b1 && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
        dt = cyc - t0;
        while (sys_reset !== 1'b0 && n < lim + 50) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= lim) begin
            failures++;
            complete_run();
        end
    endtask
    task automatic quiet(input int n);
        hits = 0;
        repeat (n) begin
            @(posedge sys_clk);
            if (sys_reset !== 1'b0) hits++;
        end
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        complete_run();
    end

    // ********************
    // Main sequence
    // ********************
    initial begin
        {rst, ext_n} = 2'b11;
        {avs_read, avs_write, special_mode, clk_edge_timeout, halt_active} = 5'h0;
        avs_address = '0;
        avs_writedata = 32'h0;
        lfsr_q = 16'h0048;
        failures = 0;
        n_checks = 0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(IDX_OPTIONS, 32'h10);
        rd_chk(IDX_SETUP, 32'h2);
        rd_chk(8'h10, 32'h0);
        bus(1'b1, IDX_OPTIONS, 32'h11);
        bus(1'b1, IDX_OPTIONS, 32'hFE);
        rd_chk(IDX_OPTIONS, 32'h19);
        check(clock_monitor_enable, 1'b1);
        bus(1'b1, IDX_OPTIONS, 32'h0);
        rd_chk(IDX_OPTIONS, 32'h11);
        // Random spacing and stray service values between arm and clear
        for (int i = 0; i < 6; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            bus(1'b1, IDX_SERVICE, 32'h55);
            bus(1'b1, IDX_SERVICE, {24'h0, lfsr_q[7:2], 2'b11});
            repeat (lfsr_q[11:8]) @(posedge sys_clk);
            bus(1'b1, IDX_SERVICE, 32'hAA);
            t0 = cyc;
            repeat (100 + lfsr_q[15:10]) @(posedge sys_clk);
        end
        bus(1'b1, IDX_SERVICE, 32'hAA);
        wait_rst(400);
        check(dt >= 4 * PS - 1 && dt <= 4 * PS + 4, 1'b1);
        t0 = cyc;
        wait_rst(200);
        check(dt >= PS - 1 && dt <= PS + 4, 1'b1);
        rd_chk(IDX_CAUSE, cause_exp(2'h2, 1'b0));
        bus(1'b1, IDX_SETUP, 32'h6);
        bus(1'b1, IDX_SETUP, 32'h0);
        rd_chk(IDX_SETUP, 32'h6);
        rd_chk(IDX_STATUS, 32'h1);
        bus(1'b1, IDX_MASK, 32'h1);
        repeat (2) @(posedge sys_clk);
        check(irq, 1'b1);
        bus(1'b1, IDX_STATUS, 32'h1);
        repeat (2) @(posedge sys_clk);
        check(irq, 1'b0);
        quiet(300);
        check(hits, 0);
        clk_edge_timeout <= 1'b1;
        quiet(20);
        check(hits, 0);
        bus(1'b1, IDX_OPTIONS, 32'h8);
        t0 = cyc;
        wait_rst(10);
        clk_edge_timeout <= 1'b0;
        rd_chk(IDX_CAUSE, cause_exp(2'h1, 1'b0));
        bus(1'b1, IDX_SETUP, 32'h4);
        halt_active <= 1'b1;
        quiet(20);
        check(hits, 0);
        bus(1'b1, IDX_OPTIONS, 32'h8);
        wait_rst(10);
        halt_active <= 1'b0;
        check(reset_vector, 16'hFFFC);
        bus(1'b1, IDX_SETUP, 32'h4);
        ext_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        check(sys_reset, 1'b1);
        ext_n <= 1'b1;
        wait_rst(20);
        rd_chk(IDX_CAUSE, cause_exp(2'h0, 1'b0));
        rd_chk(IDX_STATUS, 32'h6);
        special_mode <= 1'b1;
        rst <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(IDX_SETUP, 32'h6);
        rd_chk(IDX_TEST, 32'h1);
        bus(1'b1, IDX_SETUP, 32'h2);
        rd_chk(IDX_SETUP, 32'h2);
        quiet(150);
        check(hits, 0);
        bus(1'b1, IDX_OPTIONS, 32'h3);
        bus(1'b1, IDX_OPTIONS, 32'h20);
        rd_chk(IDX_OPTIONS, 32'h20);
        check(interrupt_edge_select, 1'b1);
        bus(1'b1, IDX_TEST, 32'h0);
        // Prescaler runs free, so service first to time from a known start
        bus(1'b1, IDX_SERVICE, 32'h55);
        bus(1'b1, IDX_SERVICE, 32'hAA);
        t0 = cyc;
        wait_rst(200);
        check(dt >= PS - 1 && dt <= PS + 4, 1'b1);
        check(reset_vector, 16'hBFFA);
        complete_run();
    end
endmodule
